/* design/ident_pkg.sv */
// Constants, types and word layouts for the identification words 49 to 79
package ident_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_GEOM = 8'h08;
  localparam logic [7:0] OFS_SPT = 8'h0c;
  localparam logic [7:0] OFS_CUR_CAP = 8'h10;
  localparam logic [7:0] OFS_NATIVE_LO = 8'h14;
  localparam logic [7:0] OFS_NATIVE_HI = 8'h18;
  localparam logic [7:0] OFS_FEAT_EN = 8'h1c;
  localparam logic [7:0] OFS_WINDOW = 8'h80;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_BUILD_BIT = 0;
  localparam int CTRL_GEN2_BIT = 1;
  localparam int CTRL_GEN3_BIT = 2;
  localparam int CTRL_MULT_VALID_BIT = 3;
  localparam int CTRL_MULT_LSB = 8;
  localparam int CTRL_DMA_LSB = 16;
  localparam int CTRL_SENS_LSB = 24;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'hffff_ff0e;

  // ----------------------------------------------------------------
  // Fixed word contents
  // ----------------------------------------------------------------
  localparam logic [15:0] W49_CAPS = 16'h2f00;
  localparam logic [15:0] W50_CAPS = 16'h4000;
  localparam logic [15:0] W51_PIO_TIMING = 16'h0200;
  localparam logic [15:0] W52_DMA_TIMING = 16'h0200;
  localparam logic [15:0] W53_VALID = 16'h0007;
  localparam logic [15:0] W59_MULT_VALID = 16'h0100;
  localparam logic [15:0] W63_MDMA_SUPPORT = 16'h0007;
  localparam logic [15:0] W64_PIO_SUPPORT = 16'h0003;
  localparam logic [15:0] W_CYCLE_TIME = 16'h0078;
  localparam logic [15:0] W75_QUEUE = 16'h001f;
  localparam logic [15:0] W76_SATA_CAPS = 16'h1702;
  localparam logic [15:0] W78_FEAT_SUP = 16'h005e;
  localparam logic [15:0] FEAT_EN_RST = 16'h0040;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Capacity saturation
  // ----------------------------------------------------------------
  localparam logic [47:0] SAT_LIMIT = 48'h0000_0fff_ffff;
  localparam logic [31:0] SAT_VALUE = 32'h0fff_ffff;

  // ----------------------------------------------------------------
  // Sector placement
  // ----------------------------------------------------------------
  localparam logic [7:0] FIRST_WORD = 8'h31;
  localparam int NUM_WORDS = 31;
  localparam logic [4:0] LAST_IDX = 5'h1e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_SEND = 2'b10
  } build_state_e;

  // Live settings frozen when a sector is built
  typedef struct packed {
    logic [15:0] cyl;
    logic [15:0] heads;
    logic [15:0] spt;
    logic [31:0] cur_cap;
    logic [31:0] user_cap;
    logic [7:0] mult;
    logic mult_valid;
    logic [7:0] dma_active;
    logic [7:0] ff_sens;
    logic gen2;
    logic gen3;
    logic [2:0] speed;
    logic [15:0] feat_en;
  } snapshot_s;

endpackage

/* design/ident_word_composer.sv */
// Combinational composer of one identification word from frozen settings
`timescale 1ns/1ns
`default_nettype none

module ident_word_composer (
  // Selection
  input wire logic [4:0] idx_i,
  input wire ident_pkg::snapshot_s snap_i,
  // Result
  output logic [15:0] word_o
);

  always_comb begin
    word_o = ident_pkg::ZERO_WORD;
    case (idx_i)
      5'h00: word_o = ident_pkg::W49_CAPS;
      5'h01: word_o = ident_pkg::W50_CAPS;
      5'h02: word_o = ident_pkg::W51_PIO_TIMING;
      5'h03: word_o = ident_pkg::W52_DMA_TIMING;
      5'h04: word_o = {snap_i.ff_sens, ident_pkg::W53_VALID[7:0]};
      5'h05: word_o = snap_i.cyl;
      5'h06: word_o = snap_i.heads;
      5'h07: word_o = snap_i.spt;
      5'h08: word_o = snap_i.cur_cap[15:0];
      5'h09: word_o = snap_i.cur_cap[31:16];
      5'h0a: begin
        word_o = {8'h00, snap_i.mult};
        if (snap_i.mult_valid) begin
          word_o = word_o | ident_pkg::W59_MULT_VALID;
        end
      end
      5'h0b: word_o = snap_i.user_cap[15:0];
      5'h0c: word_o = snap_i.user_cap[31:16];
      5'h0e: word_o = {snap_i.dma_active, ident_pkg::W63_MDMA_SUPPORT[7:0]};
      5'h0f: word_o = ident_pkg::W64_PIO_SUPPORT;
      5'h10, 5'h11, 5'h12, 5'h13: word_o = ident_pkg::W_CYCLE_TIME;
      5'h1a: word_o = ident_pkg::W75_QUEUE;
      5'h1b: word_o = ident_pkg::W76_SATA_CAPS | {12'h000, snap_i.gen3, snap_i.gen2, 2'b00};
      5'h1c: word_o = {12'h000, snap_i.speed, 1'b0};
      5'h1d: word_o = ident_pkg::W78_FEAT_SUP;
      5'h1e: word_o = snap_i.feat_en & ident_pkg::W78_FEAT_SUP;
      default: word_o = ident_pkg::ZERO_WORD;
    endcase
  end

endmodule

`default_nettype wire

/* design/ident_words.sv */
// Identification words 49 to 79: settings registers, sector build and word stream
//
// Functional notes
// - On the identify command the device returns a sector of words at fixed places.
// - Word 49 sets bits 13, 11, 10, 9 and 8.
// - Word 50 carries 01 in bits 15-14 and zero in bit 0.
// - Words 51 and 52 hold fixed legacy timing mode values.
// - Word 53 marks words 54-58, 64-70 and 88 valid; high byte is sensitivity.
// - Words 54 to 56 give current cylinders, heads and sectors per track.
// - Words 57-58 give current capacity, low half in word 57.
// - Word 59 holds multiple setting, bit 8 marks it valid, upper bits zero.
// - Words 60-61 give user addressable sectors, low half in word 60.
// - A native max above 268,435,455 reports the saturated count instead.
// - Word 63 shows active multiword DMA mode high, 7 in low byte.
// - Word 64 reports 3 in the low byte, zero above.
// - Words 65 to 68 each report 120 ns.
// - Words 69-74 are zero; word 75 reports queue depth minus one, 31.
// - Word 76 sets bits 12, 10, 9 and 8.
// - Word 76 always sets bit 1; bits 2 and 3 follow link capability.
// - Word 77 bits 3-1 show negotiated speed, other bits zero.
// - Word 78 advertises bits 6, 4, 3, 2 and 1.
// - Word 79 shows enabled features, by default only bit 6.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ident_words (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Live link and command state
  input wire logic ident_cmd_i,
  input wire logic [2:0] link_speed_i,
  // Word stream to the transport side
  input wire logic word_ready_i,
  output logic [15:0] word_o,
  output logic [7:0] word_index_o,
  output logic word_valid_o,
  output logic sector_done_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic in_window(input logic [7:0] addr);
    return (addr[7] == ident_pkg::OFS_WINDOW[7]) && (addr[6:2] <= ident_pkg::LAST_IDX);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] geom;
  logic [31:0] spt_reg;
  logic [31:0] cur_cap;
  logic [31:0] native_lo;
  logic [31:0] native_hi;
  logic [31:0] feat_en;
  logic snap_valid;
  ident_pkg::build_state_e state;
  logic [4:0] idx;
  logic [15:0] sector_buf [ident_pkg::NUM_WORDS];
  ident_pkg::snapshot_s snap;
  ident_pkg::snapshot_s next_snap;
  logic [15:0] word_c;
  logic [31:0] next_readdata;
  logic [47:0] native_max;
  logic wr_take;
  logic build_req;

  assign wr_take = avs_write_i && !avs_waitrequest_o;
  assign native_max = {native_hi[15:0], native_lo};
  // Build requests while busy are dropped so a sector in flight stays coherent
  assign build_req = ident_cmd_i ||
                     (wr_take && avs_address_i == ident_pkg::OFS_CTRL &&
                      avs_byteenable_i[0] && avs_writedata_i[ident_pkg::CTRL_BUILD_BIT]);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access; read data is ready in the same cycle waitrequest drops
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      if (!avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b1;
      end else if (avs_read_i || avs_write_i) begin
        avs_waitrequest_o <= 1'b0;
      end
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (in_window(avs_address_i)) begin
      next_readdata = {16'h0000, sector_buf[avs_address_i[6:2]]};
    end else begin
      case (avs_address_i)
        ident_pkg::OFS_CTRL: next_readdata = ctrl;
        ident_pkg::OFS_STATUS: next_readdata = {25'h0, link_speed_i, 1'b0, state, snap_valid};
        ident_pkg::OFS_GEOM: next_readdata = geom;
        ident_pkg::OFS_SPT: next_readdata = spt_reg;
        ident_pkg::OFS_CUR_CAP: next_readdata = cur_cap;
        ident_pkg::OFS_NATIVE_LO: next_readdata = native_lo;
        ident_pkg::OFS_NATIVE_HI: next_readdata = native_hi;
        ident_pkg::OFS_FEAT_EN: next_readdata = feat_en;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= ident_pkg::CTRL_RST;
    end else if (ce_i) begin
      if (wr_take && avs_address_i == ident_pkg::OFS_CTRL) begin
        ctrl <= be_merge(ctrl, avs_writedata_i, avs_byteenable_i) & ident_pkg::CTRL_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      geom <= 32'h0000_0000;
      spt_reg <= 32'h0000_0000;
      cur_cap <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_take && avs_address_i == ident_pkg::OFS_GEOM) begin
        geom <= be_merge(geom, avs_writedata_i, avs_byteenable_i);
      end
      if (wr_take && avs_address_i == ident_pkg::OFS_SPT) begin
        spt_reg <= be_merge(spt_reg, avs_writedata_i, avs_byteenable_i) & 32'h0000_ffff;
      end
      if (wr_take && avs_address_i == ident_pkg::OFS_CUR_CAP) begin
        cur_cap <= be_merge(cur_cap, avs_writedata_i, avs_byteenable_i);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      native_lo <= 32'h0000_0000;
      native_hi <= 32'h0000_0000;
    end else if (ce_i) begin
      if (wr_take && avs_address_i == ident_pkg::OFS_NATIVE_LO) begin
        native_lo <= be_merge(native_lo, avs_writedata_i, avs_byteenable_i);
      end
      if (wr_take && avs_address_i == ident_pkg::OFS_NATIVE_HI) begin
        native_hi <= be_merge(native_hi, avs_writedata_i, avs_byteenable_i) & 32'h0000_ffff;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      feat_en <= {16'h0000, ident_pkg::FEAT_EN_RST};
    end else if (ce_i) begin
      if (wr_take && avs_address_i == ident_pkg::OFS_FEAT_EN) begin
        // Only supported features can be enabled
        feat_en <= be_merge(feat_en, avs_writedata_i, avs_byteenable_i) &
                   {16'h0000, ident_pkg::W78_FEAT_SUP};
      end
    end
  end

  // ----------------------------------------------------------------
  // Snapshot of live state
  // ----------------------------------------------------------------
  always_comb begin
    next_snap.cyl = geom[15:0];
    next_snap.heads = geom[31:16];
    next_snap.spt = spt_reg[15:0];
    next_snap.cur_cap = cur_cap;
    if (native_max > ident_pkg::SAT_LIMIT) begin
      next_snap.user_cap = ident_pkg::SAT_VALUE;
    end else begin
      next_snap.user_cap = native_lo;
    end
    next_snap.mult = ctrl[ident_pkg::CTRL_MULT_LSB +: 8];
    next_snap.mult_valid = ctrl[ident_pkg::CTRL_MULT_VALID_BIT];
    next_snap.dma_active = ctrl[ident_pkg::CTRL_DMA_LSB +: 8];
    next_snap.ff_sens = ctrl[ident_pkg::CTRL_SENS_LSB +: 8];
    next_snap.gen2 = ctrl[ident_pkg::CTRL_GEN2_BIT];
    next_snap.gen3 = ctrl[ident_pkg::CTRL_GEN3_BIT];
    next_snap.speed = link_speed_i;
    next_snap.feat_en = feat_en[15:0];
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      snap <= '0;
    end else if (ce_i) begin
      if (state == ident_pkg::ST_IDLE && build_req) begin
        snap <= next_snap;
      end
    end
  end

  ident_word_composer u_composer (
    .idx_i(idx),
    .snap_i(snap),
    .word_o(word_c)
  );

  // ----------------------------------------------------------------
  // Sector buffer
  // ----------------------------------------------------------------
  for (genvar g = 0; g < ident_pkg::NUM_WORDS; g++) begin : g_buf
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        sector_buf[g] <= ident_pkg::ZERO_WORD;
      end else if (ce_i) begin
        if (state == ident_pkg::ST_FILL && idx == 5'(g)) begin
          sector_buf[g] <= word_c;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Build and stream sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ident_pkg::ST_IDLE;
      idx <= 5'h00;
      snap_valid <= 1'b0;
      word_o <= ident_pkg::ZERO_WORD;
      word_index_o <= 8'h00;
      word_valid_o <= 1'b0;
      sector_done_o <= 1'b0;
    end else if (ce_i) begin
      sector_done_o <= 1'b0;
      case (state)
        ident_pkg::ST_IDLE: begin
          if (build_req) begin
            state <= ident_pkg::ST_FILL;
            idx <= 5'h00;
            snap_valid <= 1'b0;
          end
        end
        ident_pkg::ST_FILL: begin
          if (idx == ident_pkg::LAST_IDX) begin
            state <= ident_pkg::ST_SEND;
            idx <= 5'h00;
            snap_valid <= 1'b1;
            word_o <= sector_buf[0];
            word_index_o <= ident_pkg::FIRST_WORD;
            word_valid_o <= 1'b1;
          end else begin
            idx <= idx + 5'h01;
          end
        end
        ident_pkg::ST_SEND: begin
          if (word_valid_o && word_ready_i) begin
            if (idx == ident_pkg::LAST_IDX) begin
              state <= ident_pkg::ST_IDLE;
              idx <= 5'h00;
              word_valid_o <= 1'b0;
              sector_done_o <= 1'b1;
            end else begin
              idx <= idx + 5'h01;
              word_o <= sector_buf[idx + 5'h01];
              word_index_o <= ident_pkg::FIRST_WORD + {3'b000, idx} + 8'h01;
            end
          end
        end
        default: begin
          state <= ident_pkg::ST_IDLE;
          idx <= 5'h00;
          word_valid_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* sim/ident_words_props.sv */
// Checker for the identification word stream and bus handshake
`timescale 1ns/1ns
`default_nettype none
module ident_words_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Observed ports
  input wire logic avs_waitrequest_o,
  input wire logic word_ready_i,
  input wire logic [15:0] word_o,
  input wire logic [7:0] word_index_o,
  input wire logic word_valid_o,
  input wire logic sector_done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Index on offer, zero when nothing is offered
  logic [7:0] at;
  assign at = word_valid_o ? word_index_o : 8'h00;
  sequence s_take; word_valid_o && word_ready_i; endsequence
  sequence s_last; s_take ##0 word_index_o == 8'd79; endsequence
  property p_ack; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_hold; word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o) && $stable(word_index_o); endproperty
  property p_next; s_take ##0 word_index_o != 8'd79 |=> word_valid_o && word_index_o == $past(word_index_o) + 8'd1;
  endproperty
  property p_done; s_last |=> sector_done_o && !word_valid_o ##1 !sector_done_o; endproperty
  property p_first; $rose(word_valid_o) |-> word_index_o == 8'd49; endproperty
  property p_w49; at == 8'd49 |-> word_o == 16'h2f00; endproperty
  property p_w50; at == 8'd50 |-> word_o == 16'h4000; endproperty
  property p_w51; at == 8'd51 || at == 8'd52 |-> word_o == 16'h0200; endproperty
  property p_w53; at == 8'd53 |-> word_o[7:0] == 8'h07; endproperty
  property p_w59; at == 8'd59 |-> word_o[15:9] == 7'h00; endproperty
  property p_w63; at == 8'd63 |-> word_o[7:0] == 8'h07; endproperty
  property p_w64; at == 8'd64 |-> word_o == 16'h0003; endproperty
  property p_w65; at >= 8'd65 && at <= 8'd68 |-> word_o == 16'h0078; endproperty
  property p_w69; at >= 8'd69 && at <= 8'd74 |-> word_o == 16'h0000; endproperty
  property p_w75; at == 8'd75 |-> word_o == 16'h001f; endproperty
  property p_w76; at == 8'd76 |-> (word_o & 16'hfff3) == 16'h1702; endproperty
  property p_w77; at == 8'd77 |-> word_o[15:4] == 12'h000 && !word_o[0] && word_o[3:1] inside {3'b001, 3'b010, 3'b011};
  endproperty
  property p_w78; at == 8'd78 |-> word_o == 16'h005e; endproperty
  property p_w79; at == 8'd79 |-> (word_o & 16'hffa1) == 16'h0000; endproperty
  a_ack: assert property (p_ack) else $error("waitrequest low too long");
  a_hold: assert property (p_hold) else $error("stream word changed while stalled");
  a_next: assert property (p_next) else $error("word index not in order");
  a_done: assert property (p_done) else $error("sector end wrong");
  a_first: assert property (p_first) else $error("sector does not start at 49");
  a_w49: assert property (p_w49) else $error("word 49 wrong");
  a_w50: assert property (p_w50) else $error("word 50 wrong");
  a_w51: assert property (p_w51) else $error("word 51 or 52 wrong");
  a_w53: assert property (p_w53) else $error("word 53 wrong");
  a_w59: assert property (p_w59) else $error("word 59 upper bits set");
  a_w63: assert property (p_w63) else $error("word 63 wrong");
  a_w64: assert property (p_w64) else $error("word 64 wrong");
  a_w65: assert property (p_w65) else $error("cycle time word wrong");
  a_w69: assert property (p_w69) else $error("words 69 to 74 not zero");
  a_w75: assert property (p_w75) else $error("word 75 wrong");
  a_w76: assert property (p_w76) else $error("word 76 wrong");
  a_w77: assert property (p_w77) else $error("word 77 wrong");
  a_w78: assert property (p_w78) else $error("word 78 wrong");
  a_w79: assert property (p_w79) else $error("word 79 reserved bits set");
endmodule
bind ident_words ident_words_props ident_words_props_i (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .word_ready_i(word_ready_i),
  .word_o(word_o),
  .word_index_o(word_index_o),
  .word_valid_o(word_valid_o),
  .sector_done_o(sector_done_o)
);
`default_nettype wire

/* sim/host_sink.sv */
// Host-side sink that takes identification words off the stream
`timescale 1ns/1ns
`default_nettype none
module host_sink (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Pace control
  input wire logic stall_i,
  // Word stream
  input wire logic [15:0] word_i,
  input wire logic [7:0] index_i,
  input wire logic valid_i,
  output logic ready_o
);
  logic [1:0] pace;
  logic [4:0] n;
  logic [15:0] words [31];
  logic [7:0] idx [31];
  // While stall_i is high, drops ready one cycle in four so the stream must hold its word
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pace <= 2'h0;
      ready_o <= 1'b0;
      n <= 5'h00;
    end else begin
      pace <= pace + 2'h1;
      ready_o <= !stall_i || pace != 2'h3;
      if (valid_i && ready_o) begin
        n <= (n == 5'h1e) ? 5'h00 : n + 5'h01;
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (valid_i && ready_o) begin
      words[n] <= word_i;
      idx[n] <= index_i;
    end
  end
endmodule
`default_nettype wire

/* sim/tb_ident_words.sv */
// Testbench for the identification words block
`timescale 1ns/1ns
`default_nettype none
module tb_ident_words;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, cmd = 1'b0, stall = 1'b0, ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdat, q;
  logic [2:0] spd = 3'b001;
  logic [3:0] be = 4'hf;
  logic waitreq, wvalid, done, ready;
  logic [15:0] wrd, cyl, heads, spt, feat;
  logic [7:0] widx, mult, dma, sens;
  logic [31:0] cap, user;
  logic mv, g2, g3;
  int n_errors = 0, n_checks = 0;
  always #2 clk = ~clk;
  ident_words ident_words_i (.ref_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .ident_cmd_i(cmd), .link_speed_i(spd),
    .word_ready_i(ready), .word_o(wrd), .word_index_o(widx), .word_valid_o(wvalid), .sector_done_o(done));
  host_sink host_sink_i (.ref_clk_i(clk), .reset_n_i(rst_n), .stall_i(stall), .word_i(wrd),
    .index_i(widx), .valid_i(wvalid), .ready_o(ready));
  function automatic logic [15:0] exp_word(input int i);
    case (i)
      49: exp_word = 16'h2f00;
      50: exp_word = 16'h4000;
      51, 52: exp_word = 16'h0200;
      53: exp_word = {sens, 8'h07};
      54: exp_word = cyl;
      55: exp_word = heads;
      56: exp_word = spt;
      57: exp_word = cap[15:0];
      58: exp_word = cap[31:16];
      59: exp_word = {7'h00, mv, mult};
      60: exp_word = user[15:0];
      61: exp_word = user[31:16];
      63: exp_word = {dma, 8'h07};
      64: exp_word = 16'h0003;
      65, 66, 67, 68: exp_word = 16'h0078;
      75: exp_word = 16'h001f;
      76: exp_word = {12'h170, g3, g2, 2'b10};
      77: exp_word = {12'h000, spd, 1'b0};
      78: exp_word = 16'h005e;
      79: exp_word = feat;
      default: exp_word = 16'h0000;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic setup(input logic [15:0] nhi, input logic [31:0] nlo);
    bus(1'b1, ident_pkg::OFS_CTRL, {sens, dma, mult, 4'h0, mv, g3, g2, 1'b0}, q);
    bus(1'b1, ident_pkg::OFS_GEOM, {heads, cyl}, q);
    bus(1'b1, ident_pkg::OFS_SPT, {16'h0000, spt}, q);
    bus(1'b1, ident_pkg::OFS_CUR_CAP, cap, q);
    bus(1'b1, ident_pkg::OFS_NATIVE_LO, nlo, q);
    bus(1'b1, ident_pkg::OFS_NATIVE_HI, {16'h0000, nhi}, q);
  endtask
  // A second trigger is sent mid-stream and must be ignored
  task automatic run(input logic by_reg, input int hold);
    int t;
    if (by_reg) bus(1'b1, ident_pkg::OFS_CTRL, {sens, dma, mult, 4'h0, mv, g3, g2, 1'b1}, q);
    else begin
      @(posedge clk);
      cmd <= 1'b1;
      @(posedge clk);
      cmd <= 1'b0;
    end
    t = 0;
    // Freezing mid-fill must delay the first word by exactly the frozen cycles
    if (hold > 0) begin
      @(posedge clk);
      ce <= 1'b0;
      repeat (hold) @(posedge clk);
      ce <= 1'b1;
      t = hold + 1;
    end
    while (wvalid !== 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    check("first word latency", 32 + hold, t);
    @(posedge clk);
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    while (done !== 1'b1 && t < 400) begin
      @(posedge clk);
      t++;
    end
    check("sector done", 32'h1, {31'h0, done});
    for (int i = 0; i < 31; i++) begin
      check("stream word", {16'h0, exp_word(49 + i)}, {16'h0, host_sink_i.words[i]});
      check("stream index", 49 + i, {24'h0, host_sink_i.idx[i]});
    end
    repeat (40) @(posedge clk);
    check("no second sector", 32'h0, {31'h0, wvalid});
    $display("test build done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, ident_pkg::OFS_CTRL, 32'h0, q);
    check("ctrl reset", 32'h0, q);
    bus(1'b0, ident_pkg::OFS_FEAT_EN, 32'h0, q);
    check("features reset", 32'h40, q);
    bus(1'b0, ident_pkg::OFS_STATUS, 32'h0, q);
    check("built flag", 32'h0, {31'h0, q[0]});
    bus(1'b0, ident_pkg::OFS_WINDOW, 32'h0, q);
    check("empty sector", 32'h0, q);
    bus(1'b0, 8'h40, 32'h0, q);
    check("unmapped read", 32'h0, q);
    $display("test reset done");
    cyl = 16'h3fff; heads = 16'h0010; spt = 16'h003f; cap = 32'h0123_4567; user = 32'h0abc_def0;
    mult = 8'h10; dma = 8'h02; sens = 8'h00; mv = 1'b1; g2 = 1'b1; g3 = 1'b0; feat = 16'h0040;
    spd <= 3'b010;
    setup(16'h0000, 32'h0abc_def0);
    run(1'b0, 0);
    bus(1'b0, ident_pkg::OFS_STATUS, 32'h0, q);
    check("built flag", 32'h1, {31'h0, q[0]});
    bus(1'b0, ident_pkg::OFS_WINDOW + 8'h20, 32'h0, q);
    check("sector word 57", {16'h0, cap[15:0]}, q);
    cyl = 16'h0001; heads = 16'h000f; spt = 16'h0001; cap = 32'hfedc_ba98; user = 32'h0fff_ffff;
    mult = 8'hff; dma = 8'h04; sens = 8'h5a; mv = 1'b0; g2 = 1'b0; g3 = 1'b1; feat = 16'h005e;
    spd <= 3'b011;
    stall <= 1'b1;
    bus(1'b1, ident_pkg::OFS_FEAT_EN, 32'hffff_ffff, q);
    bus(1'b0, ident_pkg::OFS_FEAT_EN, 32'h0, q);
    check("features writable", 32'h5e, q);
    setup(16'h0000, 32'h1000_0000);
    run(1'b1, 5);
    spd <= 3'b001;
    g2 = 1'b1;
    stall <= 1'b0;
    setup(16'h0001, 32'h0000_0000);
    // Upper half only: cylinders must survive the all-ones low half
    be <= 4'hc;
    bus(1'b1, ident_pkg::OFS_GEOM, 32'h0022_ffff, q);
    be <= 4'hf;
    heads = 16'h0022;
    run(1'b0, 0);
    finish_test;
  end
endmodule
`default_nettype wire
